// ==== rtl/ssrb_bank.sv ====
// serial register bank: shift register, latch decode, trigger pulses
// assumes serial pins are asynchronous to clk_sys_in and much slower
`timescale 1ns/100ps
module ssrb_bank import ssrb_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ser_clk_in,
    input wire logic ser_data_in,
    input wire logic latch_strobe_in,
    output logic [27:0] frequency_word_out,
    output logic [27:0] charge_pump_and_reference_divider_out,
    output logic [27:0] fraction_denominator_out,
    output logic [27:0] output_divider_and_power_out,
    output logic [27:0] fastlock_and_bleed_out,
    output logic [27:0] output_power_control_out,
    output logic [27:0] readback_diagnostics_out,
    output logic [27:0] status_pin_config_out,
    output logic [27:0] fixed_setup_word_a_out,
    output logic [27:0] fixed_setup_word_b_out,
    output logic [27:0] fixed_setup_word_c_out,
    output logic [27:0] lock_detect_config_out,
    output logic [27:0] vco_band_capacitor_out,
    output logic freq_cal_start_out,
    output logic fastlock_engage_out,
    output logic soft_reset_out
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] sclk_sync, sdat_sync, le_sync;
    logic sclk_d, le_d;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_sync <= 2'h0;
            sdat_sync <= 2'h0;
            // strobe idles high: reset to that level so no false latch
            le_sync <= 2'h3;
            sclk_d <= 1'b0;
            le_d <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], ser_clk_in};
            sdat_sync <= {sdat_sync[0], ser_data_in};
            le_sync <= {le_sync[0], latch_strobe_in};
            sclk_d <= sclk_sync[1];
            le_d <= le_sync[1];
        end
    end
    wire sclk_rise = sclk_sync[1] & ~sclk_d;
    wire shift_en = sclk_rise & ~le_sync[1];
    wire latch_en = le_sync[1] & ~le_d;
    // ==========================================================
    // shift register
    logic [31:0] shreg;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shreg <= 32'h00000000;
        end else if (shift_en) begin
            shreg <= {shreg[30:0], sdat_sync[1]};
        end
    end
    wire [3:0] w_addr = shreg[3:0];
    wire [27:0] w_data = shreg[31:4];
    wire [15:0] sel = latch_en ? (16'h0001 << w_addr) : 16'h0000;
    // unmapped addresses 0xB, 0xC, 0xE select nothing below
    wire swrst = sel[SSRB_A_PWR] & w_data[SSRB_SWRST_POS];
    // timeout count is the stored fastlock field, not bits of the new word
    wire [11:0] toc = fastlock_and_bleed_out[SSRB_FASTLOCK_TIMEOUT_COUNT_LSB +: SSRB_FASTLOCK_TIMEOUT_COUNT_W];
    // ==========================================================
    // registers; soft reset loads power-on values in the latch cycle
    logic [27:0] regs [16];
    localparam logic [27:0] RST_TAB [16] = '{SSRB_RST_FREQ, SSRB_RST_CPREF,
        SSRB_RST_DEN, SSRB_RST_ODIV, SSRB_RST_FLOCK, SSRB_RST_PWR,
        SSRB_RST_DIAG, SSRB_RST_STAT, SSRB_RST_FIXA, SSRB_RST_FIXB,
        SSRB_RST_FIXC, 28'h0000000, 28'h0000000, SSRB_RST_LDET,
        28'h0000000, SSRB_RST_VCAP};
    localparam logic [15:0] IMPL = 16'hA7FF;
    // unmapped slots never load, keep their zero and synthesise away
    wire [15:0] wr_hit = sel & IMPL;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            regs <= RST_TAB;
        end else if (swrst) begin
            regs <= RST_TAB;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (wr_hit[i]) begin
                    regs[i] <= w_data;
                end
            end
        end
    end
    // ==========================================================
    // trigger pulses
    wire freq_wr = sel[SSRB_A_FREQ];
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            freq_cal_start_out <= 1'b0;
            fastlock_engage_out <= 1'b0;
            soft_reset_out <= 1'b0;
        end else begin
            freq_cal_start_out <= freq_wr & ~w_data[SSRB_SKIP_CAL_POS];
            fastlock_engage_out <= freq_wr & (toc != 12'h000);
            soft_reset_out <= swrst;
        end
    end
    assign frequency_word_out = regs[0];
    assign charge_pump_and_reference_divider_out = regs[1];
    assign fraction_denominator_out = regs[2];
    assign output_divider_and_power_out = regs[3];
    assign fastlock_and_bleed_out = regs[4];
    assign output_power_control_out = regs[5];
    assign readback_diagnostics_out = regs[6];
    assign status_pin_config_out = regs[7];
    assign fixed_setup_word_a_out = regs[8];
    assign fixed_setup_word_b_out = regs[9];
    assign fixed_setup_word_c_out = regs[10];
    assign lock_detect_config_out = regs[13];
    assign vco_band_capacitor_out = regs[15];
    // ==========================================================
    // checks: software reset
    localparam int SWRST_LIM = SSRB_SWRST_MAX_CYC;
    a_swrst_bit_clear: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) swrst |=>
        !output_power_control_out[SSRB_SWRST_POS] && soft_reset_out)
        else $error("soft reset bit stayed set");
    a_swrst_defaults: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) swrst |=>
        frequency_word_out == SSRB_RST_FREQ &&
        charge_pump_and_reference_divider_out == SSRB_RST_CPREF &&
        fraction_denominator_out == SSRB_RST_DEN &&
        output_divider_and_power_out == SSRB_RST_ODIV &&
        fastlock_and_bleed_out == SSRB_RST_FLOCK &&
        output_power_control_out == SSRB_RST_PWR &&
        readback_diagnostics_out == SSRB_RST_DIAG &&
        status_pin_config_out == SSRB_RST_STAT &&
        fixed_setup_word_a_out == SSRB_RST_FIXA &&
        fixed_setup_word_b_out == SSRB_RST_FIXB &&
        fixed_setup_word_c_out == SSRB_RST_FIXC &&
        lock_detect_config_out == SSRB_RST_LDET &&
        vco_band_capacitor_out == SSRB_RST_VCAP)
        else $error("soft reset did not restore defaults");
    // the restore takes one cycle, far inside the one microsecond limit
    a_swrst_time: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) swrst |-> ##[1:SWRST_LIM] soft_reset_out)
        else $error("soft reset took too long");
    a_swrst_cause: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) soft_reset_out |-> $past(swrst))
        else $error("soft reset pulse without request");
    a_latch_power: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sel[SSRB_A_PWR] && !swrst |=>
        output_power_control_out == $past(w_data) && !soft_reset_out)
        else $error("power word not stored");
    // ==========================================================
    // checks: frequency word triggers
    a_cal_start: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) freq_wr && !w_data[SSRB_SKIP_CAL_POS]
        |=> freq_cal_start_out) else $error("calibration not started");
    a_cal_cause: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) freq_cal_start_out
        |-> $past(freq_wr) && !$past(w_data[SSRB_SKIP_CAL_POS]))
        else $error("calibration started without cause");
    a_cal_skip: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) freq_wr && w_data[SSRB_SKIP_CAL_POS]
        |=> !freq_cal_start_out) else $error("calibration not skipped");
    a_cal_single: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) freq_cal_start_out |=> !freq_cal_start_out)
        else $error("calibration start longer than one cycle");
    a_fastlock: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) fastlock_engage_out
        |-> $past(freq_wr) && $past(toc) != 12'h000)
        else $error("fastlock engage mismatch");
    a_fastlock_on: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) freq_wr && toc != 12'h000
        |=> fastlock_engage_out) else $error("fastlock not engaged");
    a_fastlock_single: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) fastlock_engage_out |=> !fastlock_engage_out)
        else $error("fastlock engage longer than one cycle");
    // ==========================================================
    // checks: latching
    a_latch_copy: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sel[SSRB_A_STAT] && !swrst
        |=> status_pin_config_out == $past(w_data))
        else $error("latched data not stored");
    a_latch_freq: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sel[SSRB_A_FREQ]
        |=> frequency_word_out == $past(w_data))
        else $error("frequency word not stored");
    a_latch_flock: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sel[SSRB_A_FLOCK]
        |=> fastlock_and_bleed_out == $past(w_data))
        else $error("fastlock word not stored");
    a_latch_vcap: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sel[SSRB_A_VCAP]
        |=> vco_band_capacitor_out == $past(w_data))
        else $error("band capacitor word not stored");
    a_data_field: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sel[SSRB_A_DEN]
        |=> fraction_denominator_out == $past(shreg[31:4]))
        else $error("data field taken from wrong bits");
    a_latch_only: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) $changed(status_pin_config_out)
        |-> $past(latch_en)) else $error("register changed without latch");
    // ==========================================================
    // checks: shifting and hold
    a_shift_msb: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) shift_en
        |=> shreg[0] == $past(sdat_sync[1]) &&
        shreg[31:1] == $past(shreg[30:0]))
        else $error("shift order wrong");
    a_shift_hold: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) !shift_en |=> $stable(shreg))
        else $error("shift without serial clock rise");
    a_hold_ignore: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) le_sync[1] && le_d
        |=> $stable(shreg)) else $error("shift while strobe high");
    a_hold_regs: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) !latch_en
        |=> $stable(frequency_word_out) && $stable(vco_band_capacitor_out))
        else $error("register changed while not latching");
    a_unmapped: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        latch_en && (w_addr inside {4'hB, 4'hC, 4'hE})
        |=> $stable(frequency_word_out) && $stable(status_pin_config_out) &&
        !freq_cal_start_out && !fastlock_engage_out && !soft_reset_out)
        else $error("unmapped write had effect");
endmodule

// ==== rtl/ssrb_pkg.sv ====
// package for the serial register bank of a frequency synthesizer
// assumes a single 200 MHz system clock; serial pins sampled into it
// Functional notes
// - reset bit set in power-control word restores every register default
// - software restore finishes well under one microsecond after the latch
// - reset bit clears itself, never stays stored
// - software restore gives the same register contents as power-on reset
// - frequency write with skip bit 0 starts core and band calibration
// - frequency write engages fastlock whenever timeout count is nonzero
// - frequency write with skip bit 1 starts no calibration
// - word is 32 bits: low four bits address, upper 28 bits data
// - strobe low: bits shift in msb first on rising serial clock
// - strobe rising edge copies data field into addressed register
// - strobe held high: serial clock pulses ignored, nothing changes
package ssrb_pkg;
    localparam int SSRB_WORD_W = 32;
    localparam int SSRB_DATA_W = 28;
    localparam int SSRB_ADDR_W = 4;
    localparam logic [3:0] SSRB_A_FREQ = 4'h0;
    localparam logic [3:0] SSRB_A_CPREF = 4'h1;
    localparam logic [3:0] SSRB_A_DEN = 4'h2;
    localparam logic [3:0] SSRB_A_ODIV = 4'h3;
    localparam logic [3:0] SSRB_A_FLOCK = 4'h4;
    localparam logic [3:0] SSRB_A_PWR = 4'h5;
    localparam logic [3:0] SSRB_A_DIAG = 4'h6;
    localparam logic [3:0] SSRB_A_STAT = 4'h7;
    localparam logic [3:0] SSRB_A_FIXA = 4'h8;
    localparam logic [3:0] SSRB_A_FIXB = 4'h9;
    localparam logic [3:0] SSRB_A_FIXC = 4'hA;
    localparam logic [3:0] SSRB_A_LDET = 4'hD;
    localparam logic [3:0] SSRB_A_VCAP = 4'hF;
    // field positions inside the 28-bit data field
    localparam int SSRB_SKIP_CAL_POS = 24;
    localparam int SSRB_FASTLOCK_TIMEOUT_COUNT_LSB = 12;
    localparam int SSRB_FASTLOCK_TIMEOUT_COUNT_W = 12;
    localparam int SSRB_SWRST_POS = 0;
    // power-on data fields; the fixed setup words carry the required values
    localparam logic [27:0] SSRB_RST_FREQ = 28'h0000000;
    localparam logic [27:0] SSRB_RST_CPREF = 28'h0000000;
    localparam logic [27:0] SSRB_RST_DEN = 28'h0000000;
    localparam logic [27:0] SSRB_RST_ODIV = 28'h0000000;
    localparam logic [27:0] SSRB_RST_FLOCK = 28'h0000000;
    localparam logic [27:0] SSRB_RST_PWR = 28'h0000000;
    localparam logic [27:0] SSRB_RST_DIAG = 28'h0000000;
    localparam logic [27:0] SSRB_RST_STAT = 28'h0000000;
    localparam logic [27:0] SSRB_RST_FIXA = 28'h207DDBF;
    localparam logic [27:0] SSRB_RST_FIXB = 28'h03C7C03;
    localparam logic [27:0] SSRB_RST_FIXC = 28'h210050C;
    localparam logic [27:0] SSRB_RST_LDET = 28'h0000410;
    localparam logic [27:0] SSRB_RST_VCAP = 28'h021FE80;
    localparam real SSRB_SWRST_MAX_NS = 1000.0;
    localparam real SSRB_CLK_NS = 5.0;
    localparam int SSRB_SWRST_MAX_CYC = int'(SSRB_SWRST_MAX_NS / SSRB_CLK_NS
        - 1.0);
endpackage

// ==== testbench/ssrb_host.sv ====
// host model driving the three-wire serial link of the register bank
// assumes the bench calls send and stray; link idles with strobe high
`timescale 1ns/100ps
module ssrb_host (
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic latch_strobe_out
);
    // serial clock stands low outside frames
    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b0;
        latch_strobe_out = 1'b1;
    end
    // whole word, msb first: data field, then four address bits
    task automatic send(input logic [31:0] w);
        latch_strobe_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            ser_data_out = w[i];
            #24 ser_clk_out = 1'b1;
            #24 ser_clk_out = 1'b0;
        end
        #24 latch_strobe_out = 1'b1;
        // released data line must not keep showing the last bit
        ser_data_out = ~w[0];
    endtask
    // strobe pulse with no clocks: latches what the shift register holds
    task automatic relatch();
        latch_strobe_out = 1'b0;
        #48 latch_strobe_out = 1'b1;
    endtask
    task automatic stray(input int n);
        repeat (n) begin
            ser_data_out = ~ser_data_out;
            #24 ser_clk_out = 1'b1;
            #24 ser_clk_out = 1'b0;
        end
    endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the serial register bank
// assumes ssrb_host drives the pins; pulses are checked from a queue
`timescale 1ns/100ps
module testbench import ssrb_pkg::*;;
    logic clk_sys_in;
    logic rst_n_in;
    wire ser_clk_in, ser_data_in, latch_strobe_in;
    logic [27:0] ro [13];
    logic freq_cal_start_out, fastlock_engage_out, soft_reset_out;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h18FCBB90;
    logic [27:0] d;
    logic [27:0] exp_reg [16];
    logic [2:0] ev_q [$];
    localparam int addrs [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 13, 15};
    ssrb_host host (.ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in),
        .latch_strobe_out(latch_strobe_in));
    ssrb_bank dut (
        .clk_sys_in, .rst_n_in, .ser_clk_in, .ser_data_in, .latch_strobe_in,
        .frequency_word_out(ro[0]),
        .charge_pump_and_reference_divider_out(ro[1]),
        .fraction_denominator_out(ro[2]),
        .output_divider_and_power_out(ro[3]),
        .fastlock_and_bleed_out(ro[4]), .output_power_control_out(ro[5]),
        .readback_diagnostics_out(ro[6]), .status_pin_config_out(ro[7]),
        .fixed_setup_word_a_out(ro[8]), .fixed_setup_word_b_out(ro[9]),
        .fixed_setup_word_c_out(ro[10]), .lock_detect_config_out(ro[11]),
        .vco_band_capacitor_out(ro[12]), .freq_cal_start_out,
        .fastlock_engage_out, .soft_reset_out);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic fail(input string m);
        num_errors++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic load_defaults();
        exp_reg = '{SSRB_RST_FREQ, SSRB_RST_CPREF, SSRB_RST_DEN,
            SSRB_RST_ODIV, SSRB_RST_FLOCK, SSRB_RST_PWR, SSRB_RST_DIAG,
            SSRB_RST_STAT, SSRB_RST_FIXA, SSRB_RST_FIXB, SSRB_RST_FIXC,
            28'h0, 28'h0, SSRB_RST_LDET, 28'h0, SSRB_RST_VCAP};
    endtask
    task automatic check_regs();
        for (int i = 0; i < 13; i++) begin
            num_checks++;
            if (ro[i] !== exp_reg[addrs[i]]) fail("register field mismatch");
        end
    endtask
    // expectation first, then the word; twelve cycles cover the latency
    task automatic wr(input logic [3:0] a, input logic [27:0] v);
        logic fl;
        fl = exp_reg[4][SSRB_FASTLOCK_TIMEOUT_COUNT_LSB +: SSRB_FASTLOCK_TIMEOUT_COUNT_W] != 0;
        if (a == SSRB_A_PWR && v[SSRB_SWRST_POS]) begin
            load_defaults();
            ev_q.push_back(3'b001);
        end else if (!(a inside {4'hB, 4'hC, 4'hE})) exp_reg[a] = v;
        if (a == SSRB_A_FREQ && (!v[SSRB_SKIP_CAL_POS] || fl))
            ev_q.push_back({!v[SSRB_SKIP_CAL_POS], fl, 1'b0});
        @(negedge clk_sys_in);
        host.send({v, a});
        repeat (12) @(negedge clk_sys_in);
        check_regs();
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    always @(negedge clk_sys_in) begin
        cycles++;
        if (cycles > 30000) begin
            fail("timeout");
            end_of_test();
        end
        if ({freq_cal_start_out, fastlock_engage_out, soft_reset_out}
            !== 3'b000) begin
            num_checks++;
            if (ev_q.size() == 0 || ev_q[0] !== {freq_cal_start_out,
                fastlock_engage_out, soft_reset_out}) begin
                fail("unexpected trigger pulse");
            end
            if (ev_q.size() != 0) void'(ev_q.pop_front());
        end
    end
    initial begin
        rst_n_in = 1'b0;
        load_defaults();
        repeat (4) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check_regs();
        for (int k = 0; k < 26; k++) begin
            seed = lfsr(seed);
            d = seed[27:0];
            if (addrs[k % 13] == 5) d[SSRB_SWRST_POS] = 1'b0;
            wr(4'(addrs[k % 13]), d);
        end
        rst_n_in = 1'b0;
        load_defaults();
        repeat (2) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check_regs();
        for (int m = 0; m < 4; m++) begin
            seed = lfsr(seed);
            d = seed[27:0] & ~(28'hFFF << SSRB_FASTLOCK_TIMEOUT_COUNT_LSB);
            wr(SSRB_A_FLOCK, m[0] ? d | (28'h1 << SSRB_FASTLOCK_TIMEOUT_COUNT_LSB) : d);
            d[SSRB_SKIP_CAL_POS] = m[1];
            wr(SSRB_A_FREQ, d);
        end
        for (int a = 11; a < 15; a++) begin
            seed = lfsr(seed);
            if (a != 13) wr(4'(a), seed[27:0]);
        end
        host.stray(5);
        host.relatch();
        repeat (12) @(negedge clk_sys_in);
        check_regs();
        wr(SSRB_A_PWR, seed[27:0] | 28'h1);
        num_checks++;
        if (ev_q.size() != 0) fail("missing trigger pulse");
        end_of_test();
    end
endmodule
